// File: common/dsr_pkg.sv
// Constants for the setup-progress status register bank.
// Assumes a 32-bit plain register port with byte addresses.
package dsr_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] DSR_OFF_STATUS   = 8'h00;
   localparam logic [7:0] DSR_OFF_OFFERED  = 8'h04;
   localparam logic [7:0] DSR_OFF_ACCEPTED = 8'h08;
   localparam logic [7:0] DSR_OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] DSR_OFF_IRQ_CLR  = 8'h10;
   localparam logic [7:0] DSR_OFF_IRQ_EN   = 8'h14;
   localparam logic [7:0] DSR_OFF_CONV_CTL = 8'h18;
   localparam logic [7:0] DSR_OFF_CONV_LO  = 8'h1c;
   localparam logic [7:0] DSR_OFF_CONV_HI  = 8'h20;
   localparam logic [7:0] DSR_OFF_IMG_LO   = 8'h24;
   localparam logic [7:0] DSR_OFF_IMG_HI   = 8'h28;

   // ------------------------------------------------------------
   // Status field bit positions
   // ------------------------------------------------------------
   localparam int DSR_BIT_FOUND     = 0;
   localparam int DSR_BIT_CAN_OP    = 1;
   localparam int DSR_BIT_READY     = 2;
   localparam int DSR_BIT_NEG_DONE  = 3;
   localparam int DSR_BIT_ERROR     = 6;
   localparam int DSR_BIT_GAVE_UP   = 7;
   localparam logic [7:0] DSR_GUEST_MASK = 8'h8f;
   localparam logic [7:0] DSR_STATUS_RST = 8'h00;

   // ------------------------------------------------------------
   // Interrupt status bit positions
   // ------------------------------------------------------------
   localparam int DSR_IRQ_W        = 3;
   localparam int DSR_IRQ_CFG_CHG  = 0;
   localparam int DSR_IRQ_READY    = 1;
   localparam int DSR_IRQ_GAVE_UP  = 2;
   localparam logic [2:0] DSR_IRQ_RST = 3'h0;

   // ------------------------------------------------------------
   // Byte-order converter control field
   // ------------------------------------------------------------
   localparam int DSR_CONV_SIZE_LSB = 0;
   localparam int DSR_CONV_BE_BIT   = 2;
   localparam logic [1:0] DSR_SIZE_16 = 2'h0;
   localparam logic [1:0] DSR_SIZE_32 = 2'h1;
   localparam logic [1:0] DSR_SIZE_64 = 2'h2;

   // Features offered by this device; the value is arbitrary
   localparam logic [31:0] DSR_OFFERED_DEF = 32'h0000_00ff;

   typedef enum logic [5:0] {
      DSR_ST_IDLE     = 6'b000001,
      DSR_ST_FOUND    = 6'b000010,
      DSR_ST_CAN_OP   = 6'b000100,
      DSR_ST_NEG_DONE = 6'b001000,
      DSR_ST_READY    = 6'b010000,
      DSR_ST_GAVE_UP  = 6'b100000
   } dsr_state_t;

endpackage : dsr_pkg

// File: rtl/dsr_field_order.sv
// Byte-order converter for shared-structure integer fields.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module dsr_field_order
   import dsr_pkg::*;
(
   input  wire logic [63:0] value_i,
   input  wire logic [1:0]  size_i,
   input  wire logic        big_end_i,
   output logic      [63:0] image_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [63:0] dsr_swap(input logic [63:0] v,
                                            input int nbytes);
      logic [63:0] r;
      r = 64'h0;
      for (int i = 0; i < 8; i++) begin
         if (i < nbytes) begin
            r[8*i +: 8] = v[8*(nbytes-1-i) +: 8];
         end
      end
      return r;
   endfunction : dsr_swap

   // ------------------------------------------------------------
   // Conversion
   // ------------------------------------------------------------
   // Image byte 0 sits in bits 7:0 and is the lowest memory address.
   // Unused upper bytes read zero, so fields stay unsigned.
   logic [63:0] masked;
   int          nbytes;

   always_comb begin
      nbytes = 8;
      if (size_i == DSR_SIZE_16) begin
         nbytes = 2;
      end else if (size_i == DSR_SIZE_32) begin
         nbytes = 4;
      end
      masked = value_i;
      for (int i = 0; i < 8; i++) begin
         if (i >= nbytes) begin
            masked[8*i +: 8] = 8'h00;
         end
      end
      if (big_end_i) begin
         image_o = dsr_swap(masked, nbytes);
      end else begin
         image_o = masked;
      end
   end

endmodule : dsr_field_order

// File: rtl/dsr_status_bank.sv
// Setup-progress status register bank with feature negotiation,
// interrupt status and a shared-field byte-order converter.
// Assumes a same-clock register master that never waits and a
// device core that reports faults and notify requests on this clock.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps

// Function
// - Status bit value 1 is the guest_found_flag set by the guest.
// - Status bit value 2 is the guest_can_operate_flag, set any time later.
// - Status bit value 128 is the guest_gave_up_flag set on abandonment.
// - Status bit value 8 is the negotiation_done_flag after acceptance.
// - Status bit value 4 is the host_side_ready_flag when fully set up.
// - The device reports an unrecoverable fault on status bit value 64.
// - The device offers features 0 to 7 and the guest accepts a subset.
// - Bit-fields pack upward from the least significant bit, unsigned.
// - Shared structures carry no padding between fields.
// - le16, le32 and le64 fields store the low byte first.
// - be16, be32 and be64 fields store the high byte first.
// - A group of bit-fields lies wholly inside one integer field.
// - Device reset clears the whole status register to zero.
// - No buffer use or guest notify before host_side_ready_flag.
// - A fault raised while ready sends a config-change notification.
module dsr_status_bank
   import dsr_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic        dev_fault_i,
   input  wire logic        notify_req_i,
   output logic             notify_o,
   output logic             consume_en_o,
   output logic             cfg_change_o,
   output logic             dev_reset_o,
   output logic [31:0]      active_features_o,
   output logic [7:0]       status_o,
   output logic             irq_o
);

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   logic wr_status;
   logic wr_accept;
   logic wr_irq_clr;
   logic wr_irq_en;
   logic wr_conv_ctl;
   logic wr_conv_lo;
   logic wr_conv_hi;

   always_comb begin
      wr_status   = 1'b0;
      wr_accept   = 1'b0;
      wr_irq_clr  = 1'b0;
      wr_irq_en   = 1'b0;
      wr_conv_ctl = 1'b0;
      wr_conv_lo  = 1'b0;
      wr_conv_hi  = 1'b0;
      if (!reg_wr_i) begin
         wr_status = 1'b0;
      end else if (reg_addr_i == DSR_OFF_STATUS) begin
         wr_status = 1'b1;
      end else if (reg_addr_i == DSR_OFF_ACCEPTED) begin
         wr_accept = 1'b1;
      end else if (reg_addr_i == DSR_OFF_IRQ_CLR) begin
         wr_irq_clr = 1'b1;
      end else if (reg_addr_i == DSR_OFF_IRQ_EN) begin
         wr_irq_en = 1'b1;
      end else if (reg_addr_i == DSR_OFF_CONV_CTL) begin
         wr_conv_ctl = 1'b1;
      end else if (reg_addr_i == DSR_OFF_CONV_LO) begin
         wr_conv_lo = 1'b1;
      end else if (reg_addr_i == DSR_OFF_CONV_HI) begin
         wr_conv_hi = 1'b1;
      end
   end

   // A status write of zero is the guest's request to reset the device
   logic soft_reset;
   assign soft_reset = wr_status && (reg_wdata_i[7:0] == 8'h00);
   assign dev_reset_o = soft_reset;

   // ------------------------------------------------------------
   // Status and feature state
   // ------------------------------------------------------------
   logic [7:0]  guest_bits_q;
   logic [7:0]  guest_bits_d;
   logic        fault_q;
   logic        fault_d;
   logic [31:0] accepted_q;
   logic [31:0] accepted_d;
   logic [7:0]  status_rd;
   logic [7:0]  req_bits;
   logic        unoffered;

   // Only bits the device offered may be accepted
   assign unoffered = |(accepted_q & ~DSR_OFFERED_DEF);

   always_comb begin
      guest_bits_d = guest_bits_q;
      fault_d      = fault_q;
      accepted_d   = accepted_q;
      req_bits     = reg_wdata_i[7:0] & DSR_GUEST_MASK;
      // A bad feature subset leaves negotiation_done_flag unset
      if (unoffered) begin
         req_bits[DSR_BIT_NEG_DONE] = 1'b0;
      end
      if (soft_reset) begin
         guest_bits_d = DSR_STATUS_RST;
         fault_d      = 1'b0;
         accepted_d   = 32'h0;
      end else begin
         if (wr_status) begin
            // Writes only add bits; a stray clear is ignored
            guest_bits_d = guest_bits_q | req_bits;
         end
         // Accepted set freezes once negotiation is done
         if (wr_accept && !guest_bits_q[DSR_BIT_NEG_DONE]) begin
            accepted_d = reg_wdata_i;
         end
         if (dev_fault_i) begin
            fault_d = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         guest_bits_q <= DSR_STATUS_RST;
         fault_q      <= 1'b0;
         accepted_q   <= 32'h0;
      end else begin
         guest_bits_q <= guest_bits_d;
         fault_q      <= fault_d;
         accepted_q   <= accepted_d;
      end
   end

   // All flags live in one 8-bit field, packed from bit 0 upward
   always_comb begin
      status_rd = guest_bits_q;
      status_rd[DSR_BIT_FOUND]    = guest_bits_q[DSR_BIT_FOUND];
      status_rd[DSR_BIT_CAN_OP]   = guest_bits_q[DSR_BIT_CAN_OP];
      status_rd[DSR_BIT_READY]    = guest_bits_q[DSR_BIT_READY];
      status_rd[DSR_BIT_NEG_DONE] = guest_bits_q[DSR_BIT_NEG_DONE];
      status_rd[DSR_BIT_GAVE_UP]  = guest_bits_q[DSR_BIT_GAVE_UP];
      status_rd[DSR_BIT_ERROR]    = fault_q;
   end

   assign status_o = status_rd;
   assign active_features_o = guest_bits_q[DSR_BIT_NEG_DONE] ?
                              accepted_q : 32'h0;

   // ------------------------------------------------------------
   // Setup progress tracker
   // ------------------------------------------------------------
   // Mirrors the furthest step reached; drives nothing but the
   // ready gate so that a late found or can-operate bit is harmless.
   dsr_state_t state_q;
   dsr_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         DSR_ST_IDLE: begin
            if (guest_bits_q[DSR_BIT_FOUND]) begin
               state_d = DSR_ST_FOUND;
            end
         end
         DSR_ST_FOUND: begin
            // May sit here indefinitely before the next step
            if (guest_bits_q[DSR_BIT_CAN_OP]) begin
               state_d = DSR_ST_CAN_OP;
            end
         end
         DSR_ST_CAN_OP: begin
            if (guest_bits_q[DSR_BIT_NEG_DONE]) begin
               state_d = DSR_ST_NEG_DONE;
            end
         end
         DSR_ST_NEG_DONE: begin
            if (guest_bits_q[DSR_BIT_READY]) begin
               state_d = DSR_ST_READY;
            end
         end
         DSR_ST_READY: begin
            state_d = DSR_ST_READY;
         end
         DSR_ST_GAVE_UP: begin
            state_d = DSR_ST_GAVE_UP;
         end
         default: begin
            state_d = DSR_ST_IDLE;
         end
      endcase
      if (guest_bits_q[DSR_BIT_GAVE_UP]) begin
         state_d = DSR_ST_GAVE_UP;
      end
      if (soft_reset) begin
         state_d = DSR_ST_IDLE;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q <= DSR_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   logic ready;
   // The gave-up bit gates at once; the tracker lags it by one cycle
   assign ready = guest_bits_q[DSR_BIT_READY]
                  && !guest_bits_q[DSR_BIT_GAVE_UP]
                  && (state_q != DSR_ST_GAVE_UP);

   // ------------------------------------------------------------
   // Buffer use and notifications
   // ------------------------------------------------------------
   assign consume_en_o = ready;
   assign notify_o     = notify_req_i && ready;

   // Fault rising edge while ready; the first fault latches the flag
   logic fault_rise;
   logic cfg_chg_q;
   logic cfg_chg_d;
   assign fault_rise = dev_fault_i && !fault_q && !soft_reset;

   always_comb begin
      // Owed whenever ready was set, even after the guest gave up
      cfg_chg_d = fault_rise && guest_bits_q[DSR_BIT_READY];
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg_chg_q <= 1'b0;
      end else begin
         cfg_chg_q <= cfg_chg_d;
      end
   end

   assign cfg_change_o = cfg_chg_q;

   // ------------------------------------------------------------
   // Interrupt status, clear and enable
   // ------------------------------------------------------------
   logic [DSR_IRQ_W-1:0] irq_stat_q;
   logic [DSR_IRQ_W-1:0] irq_stat_d;
   logic [DSR_IRQ_W-1:0] irq_en_q;
   logic [DSR_IRQ_W-1:0] irq_en_d;
   logic [DSR_IRQ_W-1:0] irq_set;
   logic [DSR_IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_set = '0;
      irq_set[DSR_IRQ_CFG_CHG] = cfg_chg_q;
      irq_set[DSR_IRQ_READY]   = wr_status && req_bits[DSR_BIT_READY]
                                 && !guest_bits_q[DSR_BIT_READY];
      irq_set[DSR_IRQ_GAVE_UP] = wr_status && req_bits[DSR_BIT_GAVE_UP]
                                 && !guest_bits_q[DSR_BIT_GAVE_UP];
      irq_clr = wr_irq_clr ? reg_wdata_i[DSR_IRQ_W-1:0] : '0;
      // A new event wins over a clear in the same cycle
      irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
      irq_en_d   = wr_irq_en ? reg_wdata_i[DSR_IRQ_W-1:0] : irq_en_q;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_stat_q <= DSR_IRQ_RST;
         irq_en_q   <= DSR_IRQ_RST;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_en_q   <= irq_en_d;
      end
   end

   assign irq_o = |(irq_stat_q & irq_en_q);

   // ------------------------------------------------------------
   // Shared-field byte-order converter
   // ------------------------------------------------------------
   logic [2:0]  conv_ctl_q;
   logic [2:0]  conv_ctl_d;
   logic [63:0] conv_val_q;
   logic [63:0] conv_val_d;
   logic [63:0] img_q;
   logic [63:0] img_d;
   logic [63:0] img_comb;

   always_comb begin
      conv_ctl_d = wr_conv_ctl ? reg_wdata_i[2:0] : conv_ctl_q;
      conv_val_d = conv_val_q;
      // The two halves abut with no gap between them
      if (wr_conv_lo) begin
         conv_val_d[31:0] = reg_wdata_i;
      end
      if (wr_conv_hi) begin
         conv_val_d[63:32] = reg_wdata_i;
      end
      img_d = img_comb;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         conv_ctl_q <= 3'h0;
         conv_val_q <= 64'h0;
         img_q      <= 64'h0;
      end else begin
         conv_ctl_q <= conv_ctl_d;
         conv_val_q <= conv_val_d;
         img_q      <= img_d;
      end
   end

   dsr_field_order u_order (
      .value_i   (conv_val_q),
      .size_i    (conv_ctl_q[DSR_CONV_SIZE_LSB +: 2]),
      .big_end_i (conv_ctl_q[DSR_CONV_BE_BIT]),
      .image_o   (img_comb)
   );

   // ------------------------------------------------------------
   // Read path: data stand only in the cycle after the strobe
   // ------------------------------------------------------------
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   always_comb begin
      rdata_d = 32'h0;
      if (!reg_rd_i) begin
         rdata_d = 32'h0;
      end else if (reg_addr_i == DSR_OFF_STATUS) begin
         rdata_d = {24'h0, status_rd};
      end else if (reg_addr_i == DSR_OFF_OFFERED) begin
         rdata_d = DSR_OFFERED_DEF;
      end else if (reg_addr_i == DSR_OFF_ACCEPTED) begin
         rdata_d = accepted_q;
      end else if (reg_addr_i == DSR_OFF_IRQ_STAT) begin
         rdata_d = {29'h0, irq_stat_q};
      end else if (reg_addr_i == DSR_OFF_IRQ_EN) begin
         rdata_d = {29'h0, irq_en_q};
      end else if (reg_addr_i == DSR_OFF_CONV_CTL) begin
         rdata_d = {29'h0, conv_ctl_q};
      end else if (reg_addr_i == DSR_OFF_CONV_LO) begin
         rdata_d = conv_val_q[31:0];
      end else if (reg_addr_i == DSR_OFF_CONV_HI) begin
         rdata_d = conv_val_q[63:32];
      end else if (reg_addr_i == DSR_OFF_IMG_LO) begin
         rdata_d = img_q[31:0];
      end else if (reg_addr_i == DSR_OFF_IMG_HI) begin
         rdata_d = img_q[63:32];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule : dsr_status_bank

// File: testbench/dsr_guest_model.sv
// Guest driver model: master of the plain register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module dsr_guest_model
   import dsr_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic [31:0] reg_rdata_i,
   output logic      [7:0]  reg_addr_o,
   output logic      [31:0] reg_wdata_o,
   output logic             reg_wr_o,
   output logic             reg_rd_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 32'h0;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // Callers write only new status bits, or zero to reset
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      // Idle data show garbage so a stale word is never taken as valid
      reg_wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      @(posedge core_clk_i);
      d = reg_rdata_i;
   endtask : rd
endmodule : dsr_guest_model

// File: testbench/dsr_status_bank_chk.sv
// Port-level checks for the status register bank, bound to its top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module dsr_status_bank_chk
   import dsr_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        dev_fault_i,
   input wire logic        notify_req_i,
   input wire logic        notify_o,
   input wire logic        consume_en_o,
   input wire logic        cfg_change_o,
   input wire logic        dev_reset_o,
   input wire logic [31:0] active_features_o,
   input wire logic [7:0]  status_o,
   input wire logic        irq_o
);
   logic [7:0] st_q;
   logic [7:0] wd_q;

   // Last status and write byte, for relations across one edge
   always_ff @(posedge core_clk_i) begin
      st_q <= status_o;
      wd_q <= reg_wdata_i[7:0];
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_set_wr;
      reg_wr_i && reg_addr_i == DSR_OFF_STATUS && reg_wdata_i[7:0] != 8'h00;
   endsequence
   sequence s_zero_wr;
      reg_wr_i && reg_addr_i == DSR_OFF_STATUS && reg_wdata_i[7:0] == 8'h00;
   endsequence
   sequence s_new_fault;
      dev_fault_i && !dev_reset_o && status_o[DSR_BIT_READY]
      && !status_o[DSR_BIT_ERROR];
   endsequence

   a_rdata_idle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data not zero outside a read slot");
   a_read_back: assert property (
      reg_rd_i && reg_addr_i == DSR_OFF_STATUS && !dev_fault_i
      |=> reg_rdata_o == {24'h0, st_q})
      else $error("status read back wrong");
   // Negotiation bit left out: it may be refused
   a_or_set: assert property (
      s_set_wr |=> ((status_o ^ (st_q | wd_q)) & 8'h87) == 8'h00)
      else $error("status write did not OR guest bits");
   a_soft_reset: assert property (
      s_zero_wr |-> dev_reset_o ##1 status_o == 8'h00)
      else $error("zero write did not clear status");
   a_hard_reset: assert property (
      disable iff (1'b0) rst_i |=> status_o == 8'h00 && !irq_o)
      else $error("reset did not clear status");
   a_fault_sets: assert property (
      dev_fault_i && !dev_reset_o |=> status_o[DSR_BIT_ERROR])
      else $error("fault flag not raised");
   a_cfg_pulse: assert property (
      s_new_fault |=> cfg_change_o ##1 !cfg_change_o)
      else $error("config change pulse wrong");
   a_cfg_cause: assert property (
      cfg_change_o |-> st_q[DSR_BIT_READY] && !st_q[DSR_BIT_ERROR])
      else $error("config change without cause");
   a_notify_gate: assert property (
      notify_o |-> notify_req_i && status_o[DSR_BIT_READY])
      else $error("notify before ready");
   a_consume_gate: assert property (
      consume_en_o == (status_o[DSR_BIT_READY] && !status_o[DSR_BIT_GAVE_UP]))
      else $error("consume enable wrong");
   a_feat_gate: assert property (
      active_features_o != 32'h0 |-> status_o[DSR_BIT_NEG_DONE]
      && (active_features_o & ~DSR_OFFERED_DEF) == 32'h0)
      else $error("active features not an accepted subset");
endmodule : dsr_status_bank_chk

bind dsr_status_bank dsr_status_bank_chk u_chk (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .dev_fault_i(dev_fault_i),
   .notify_req_i(notify_req_i), .notify_o(notify_o),
   .consume_en_o(consume_en_o), .cfg_change_o(cfg_change_o),
   .dev_reset_o(dev_reset_o), .active_features_o(active_features_o),
   .status_o(status_o), .irq_o(irq_o));

// File: testbench/dsr_status_bank_tb.sv
// Self-checking bench for the status register bank.
// Assumes the guest model is the only master of the register port.
`timescale 1ns/1ps
module dsr_status_bank_tb
   import dsr_pkg::*;
;
   typedef struct packed {
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [7:0]  ra;
      logic [31:0] ex;
   } dsr_row_t;

   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        dev_fault_i = 1'b0;
   logic        notify_req_i = 1'b0;
   logic [7:0]  reg_addr_i, status_o;
   logic [31:0] reg_wdata_i, reg_rdata_o, active_features_o, rv;
   logic        reg_wr_i, reg_rd_i, notify_o, consume_en_o;
   logic        cfg_change_o, dev_reset_o, irq_o;
   int          n_errors = 0;
   int          checks_done = 0;
   dsr_row_t    rows [19] = '{
      '{DSR_OFF_IRQ_EN, 32'h7, DSR_OFF_IRQ_EN, 32'h7},
      '{DSR_OFF_STATUS, 32'h01, DSR_OFF_STATUS, 32'h01},
      '{DSR_OFF_STATUS, 32'h02, DSR_OFF_STATUS, 32'h03},
      '{DSR_OFF_OFFERED, 32'hffffff00, DSR_OFF_OFFERED, 32'hff},
      '{DSR_OFF_ACCEPTED, 32'h0f, DSR_OFF_ACCEPTED, 32'h0f},
      '{DSR_OFF_STATUS, 32'h08, DSR_OFF_STATUS, 32'h0b},
      '{DSR_OFF_STATUS, 32'h34, DSR_OFF_STATUS, 32'h0f},
      '{DSR_OFF_IRQ_CLR, 32'h0, DSR_OFF_IRQ_STAT, 32'h2},
      '{DSR_OFF_IRQ_CLR, 32'h2, DSR_OFF_IRQ_STAT, 32'h0},
      '{8'h3c, 32'h5, 8'h3c, 32'h0},
      '{DSR_OFF_CONV_CTL, 32'h0, DSR_OFF_STATUS, 32'h0f},
      '{DSR_OFF_CONV_LO, 32'h12345678, DSR_OFF_IMG_LO, 32'h5678},
      '{DSR_OFF_CONV_HI, 32'h9abcdef0, DSR_OFF_IMG_HI, 32'h0},
      '{DSR_OFF_CONV_CTL, 32'h4, DSR_OFF_IMG_LO, 32'h7856},
      '{DSR_OFF_CONV_CTL, 32'h1, DSR_OFF_IMG_LO, 32'h12345678},
      '{DSR_OFF_CONV_CTL, 32'h5, DSR_OFF_IMG_LO, 32'h78563412},
      '{DSR_OFF_CONV_CTL, 32'h3, DSR_OFF_IMG_HI, 32'h9abcdef0},
      '{DSR_OFF_CONV_CTL, 32'h6, DSR_OFF_IMG_HI, 32'h78563412},
      '{DSR_OFF_CONV_CTL, 32'h6, DSR_OFF_IMG_LO, 32'hf0debc9a}};

   always #5 core_clk_i = ~core_clk_i;

   dsr_status_bank u_dsr_status_bank (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .dev_fault_i(dev_fault_i),
      .notify_req_i(notify_req_i), .notify_o(notify_o),
      .consume_en_o(consume_en_o), .cfg_change_o(cfg_change_o),
      .dev_reset_o(dev_reset_o), .active_features_o(active_features_o),
      .status_o(status_o), .irq_o(irq_o));

   dsr_guest_model u_dsr_guest_model (
      .core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata_o),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

   // ------------------------------------------------------------
   // Compare and bus helpers
   // ------------------------------------------------------------
   task automatic chk32(input logic [31:0] got, input logic [31:0] ex);
      checks_done++;
      if (got !== ex) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic ex);
      chk32({31'h0, got}, {31'h0, ex});
   endtask : chk1

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
      u_dsr_guest_model.rd(a, rv);
      chk32(rv, ex);
   endtask : rdchk

   task automatic fault_pulse;
      @(posedge core_clk_i);
      dev_fault_i <= 1'b1;
      @(posedge core_clk_i);
      dev_fault_i <= 1'b0;
      #1;
   endtask : fault_pulse

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (3000) @(posedge core_clk_i);
      n_errors++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         u_dsr_guest_model.wr(rows[i].wa, rows[i].wd);
         // Converter image lands one cycle after its write
         repeat (2) @(posedge core_clk_i);
         rdchk(rows[i].ra, rows[i].ex);
      end
      $display("test rows done");
      @(posedge core_clk_i);
      notify_req_i <= 1'b1;
      #1;
      chk1(notify_o, 1'b1);
      chk1(consume_en_o, 1'b1);
      chk32(active_features_o, 32'h0f);
      fault_pulse();
      chk1(cfg_change_o, 1'b1);
      chk32({24'h0, status_o}, 32'h4f);
      @(posedge core_clk_i);
      #1;
      chk1(cfg_change_o, 1'b0);
      chk1(irq_o, 1'b1);
      rdchk(DSR_OFF_IRQ_STAT, 32'h1);
      fault_pulse();
      chk1(cfg_change_o, 1'b0);
      u_dsr_guest_model.wr(DSR_OFF_IRQ_CLR, 32'h1);
      #1;
      chk1(irq_o, 1'b0);
      $display("test fault done");
      u_dsr_guest_model.wr(DSR_OFF_STATUS, 32'h80);
      #1;
      chk1(consume_en_o, 1'b0);
      rdchk(DSR_OFF_STATUS, 32'hcf);
      rdchk(DSR_OFF_IRQ_STAT, 32'h4);
      u_dsr_guest_model.wr(DSR_OFF_STATUS, 32'h0);
      #1;
      chk32({24'h0, status_o}, 32'h0);
      chk1(notify_o, 1'b0);
      chk32(active_features_o, 32'h0);
      $display("test gave up done");
      u_dsr_guest_model.wr(DSR_OFF_ACCEPTED, 32'h100);
      u_dsr_guest_model.wr(DSR_OFF_STATUS, 32'h08);
      rdchk(DSR_OFF_STATUS, 32'h0);
      u_dsr_guest_model.wr(DSR_OFF_ACCEPTED, 32'h3);
      u_dsr_guest_model.wr(DSR_OFF_STATUS, 32'h08);
      u_dsr_guest_model.wr(DSR_OFF_ACCEPTED, 32'hff);
      rdchk(DSR_OFF_ACCEPTED, 32'h3);
      $display("test negotiation done");
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      chk32({24'h0, status_o}, 32'h0);
      chk1(irq_o, 1'b0);
      $display("test reset done");
      summarize();
   end
endmodule : dsr_status_bank_tb
